// ### design/power_resource_pkg.sv
package power_resource_pkg;

   // register offsets (byte addresses on the control bus)
   localparam logic [7:0] USB_LDO_SETTINGS_TWO_OFF      = 8'hD9;
   localparam logic [7:0] REGULATOR_ENABLE_OUT_GROUP_OFF = 8'hDA;
   localparam logic [7:0] REGULATOR_ENABLE_OUT_TYPE_OFF  = 8'hDB;
   localparam logic [7:0] REGULATOR_ENABLE_OUT_REMAP_OFF = 8'hDC;
   localparam logic [7:0] POWERON_RESET_OUT_GROUP_OFF    = 8'hDD;
   localparam logic [7:0] POWERON_RESET_OUT_TYPE_OFF     = 8'hDE;
   localparam logic [7:0] POWERON_RESET_OUT_REMAP_OFF    = 8'hDF;
   localparam logic [7:0] CLOCK_REQUEST_OUT_GROUP_OFF    = 8'hE0;
   localparam logic [7:0] CLOCK_REQUEST_OUT_TYPE_OFF     = 8'hE1;
   localparam logic [7:0] CLOCK_REQUEST_OUT_REMAP_OFF    = 8'hE2;
   localparam logic [7:0] SYSTEM_ENABLE_OUT_GROUP_OFF    = 8'hE3;
   localparam logic [7:0] SYSTEM_ENABLE_OUT_TYPE_OFF     = 8'hE4;
   localparam logic [7:0] SYSTEM_ENABLE_OUT_REMAP_OFF    = 8'hE5;
   localparam logic [7:0] FAST_CLOCK_OUT_GROUP_OFF       = 8'hE6;

   // resource group register fields
   localparam int GROUP_FIELD_MSB = 7;
   localparam int GROUP_FIELD_LSB = 5;
   localparam int WARM_CFG_BIT    = 4;
   localparam int STATE_FIELD_MSB = 3;
   localparam int STATE_FIELD_LSB = 0;

   // resource type register fields
   localparam int SECONDARY_KIND_MSB = 4;
   localparam int SECONDARY_KIND_LSB = 3;
   localparam int PRIMARY_KIND_MSB   = 2;
   localparam int PRIMARY_KIND_LSB   = 0;

   // remap register fields
   localparam int OFF_REMAP_MSB   = 7;
   localparam int OFF_REMAP_LSB   = 4;
   localparam int SLEEP_REMAP_MSB = 3;
   localparam int SLEEP_REMAP_LSB = 0;

   // usb settings register fields
   localparam int USB_HIGH_LDO_SLEEP_REMAP_BIT = 3;

   // reset values
   localparam logic [2:0] GROUP_RESET          = 3'h7;
   localparam logic [2:0] GROUP_ALL            = 3'h7;
   localparam logic       WARM_CFG_RESET       = 1'h0;
   localparam logic [3:0] STATE_RESET          = 4'h0;
   localparam logic [1:0] SECONDARY_KIND_RESET = 2'h0;
   localparam logic [2:0] REGULATOR_ENABLE_OUTPUT_KIND_RESET     = 3'h2;
   localparam logic [2:0] PORST_KIND_RESET     = 3'h0;
   localparam logic [2:0] CLKREQ_KIND_RESET    = 3'h3;
   localparam logic [2:0] SYSTEM_ENABLE_OUTPUT_KIND_RESET     = 3'h6;
   localparam logic [3:0] OFF_REMAP_RESET      = 4'h0;
   localparam logic [3:0] SLEEP_REMAP_RESET    = 4'h8;
   localparam logic       USB_SLEEP_REMAP_RESET = 1'h1;
   localparam logic       GAIN_TRIM_RESET       = 1'h0;

   // number of resources with group, type and remap registers
   localparam int NUM_FULL_RES = 4;

   // one resource's settings as seen by the sequencer
   typedef struct packed {
      logic [2:0] processor_group_select;
      logic       warm_cfg;
      logic [1:0] secondary_resource_kind;
      logic [2:0] primary_resource_kind;
      logic [3:0] off_remap;
      logic [3:0] sleep_remap;
   } resource_cfg_type;

   // one register access from the control bus
   typedef struct packed {
      logic       wr_en;
      logic       rd_en;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_access_type;

endpackage

// ### design/resource_group_reg.sv
`timescale 1ns/1ps
// one resource group register with warm-reset handling
module resource_group_reg
   import power_resource_pkg::*;
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       reset_n,
   // host write
   input  wire logic       wr_en,
   input  wire logic [7:0] wdata,
   // sequencer side
   input  wire logic       warm_reset,
   input  wire logic [3:0] res_state,
   // register image
   output logic [7:0]      reg_value,
   output logic [2:0]      group_sel,
   output logic            warm_cfg
);

   logic [2:0] group_ff;     // processor group field
   logic       warm_cfg_ff;  // warm-reset configuration bit
   logic [3:0] state_ff;     // sampled resource state

   // group field and warm-cfg bit
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         group_ff    <= GROUP_RESET;
         warm_cfg_ff <= WARM_CFG_RESET;
      end else begin
         if (wr_en) begin
            group_ff    <= wdata[GROUP_FIELD_MSB:GROUP_FIELD_LSB];
            warm_cfg_ff <= wdata[WARM_CFG_BIT];
         end
         if (warm_reset && warm_cfg_ff) begin
            group_ff <= GROUP_ALL;
         end
      end
   end

   // current state, read-only
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= STATE_RESET;
      end else begin
         state_ff <= res_state;
      end
   end

   assign reg_value = {group_ff, warm_cfg_ff, state_ff};
   assign group_sel = group_ff;
   assign warm_cfg  = warm_cfg_ff;

endmodule

// ### design/resource_kind_remap_reg.sv
`timescale 1ns/1ps
// one resource type register plus remap register
module resource_kind_remap_reg
   import power_resource_pkg::*;
#(
   parameter logic [2:0] KIND_RESET = 3'h0
) (
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       reset_n,
   // host writes
   input  wire logic       type_wr_en,
   input  wire logic       remap_wr_en,
   input  wire logic [7:0] wdata,
   // register images
   output logic [7:0]      type_value,
   output logic [7:0]      remap_value
);

   logic [1:0] kind2_ff;  // secondary kind
   logic [2:0] kind_ff;   // primary kind
   logic [3:0] off_ff;    // off-mode remap
   logic [3:0] sleep_ff;  // sleep-mode remap

   // type register
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         kind2_ff <= SECONDARY_KIND_RESET;
         kind_ff  <= KIND_RESET;
      end else if (type_wr_en) begin
         kind2_ff <= wdata[SECONDARY_KIND_MSB:SECONDARY_KIND_LSB];
         kind_ff  <= wdata[PRIMARY_KIND_MSB:PRIMARY_KIND_LSB];
      end
   end

   // remap register
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         off_ff   <= OFF_REMAP_RESET;
         sleep_ff <= SLEEP_REMAP_RESET;
      end else if (remap_wr_en) begin
         off_ff   <= wdata[OFF_REMAP_MSB:OFF_REMAP_LSB];
         sleep_ff <= wdata[SLEEP_REMAP_MSB:SLEEP_REMAP_LSB];
      end
   end

   assign type_value  = {3'h0, kind2_ff, kind_ff};
   assign remap_value = {off_ff, sleep_ff};

endmodule

// ### design/power_resource_config_bank.sv
`timescale 1ns/1ps
module power_resource_config_bank
   import power_resource_pkg::*;
(
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             reset_n,
   // register access from the control bus decoder
   input  wire logic             reg_wr_en,
   input  wire logic             reg_rd_en,
   input  wire logic [7:0]       reg_addr,
   input  wire logic [7:0]       reg_wdata,
   output logic [7:0]            reg_rdata,
   output logic                  reg_rvalid,
   output logic                  reg_hit,
   // sequencer inputs
   input  wire logic [4:0]       warm_reset,
   input  wire logic [19:0]      res_state,
   input  wire logic             usb_high_ldo_off,
   input  wire logic             gain_trim_wr_en,   // trim bit write pulse
   input  wire logic             gain_trim_wdata,   // trim bit value
   // settings out to the sequencer
   output resource_cfg_type [3:0] res_cfg,
   output logic [2:0]            fast_clock_output_group,
   output logic                  usb_high_ldo_sleep_remap,
   output logic                  gain_trim_low_bit
);

   reg_access_type         acc;          // bundled access
   logic [4:0]             group_wr;     // group write strobes
   logic [3:0]             type_wr;      // type write strobes
   logic [3:0]             remap_wr;     // remap write strobes
   logic [4:0][7:0]        group_val;    // group register images
   logic [4:0][2:0]        group_sel;    // group fields
   logic [4:0]             warm_cfg;     // warm cfg bits
   logic [3:0][7:0]        type_val;     // type register images
   logic [3:0][7:0]        remap_val;    // remap register images
   logic                   usb_remap_ff; // usb high ldo remap bit
   logic                   gain_trim_ff; // gain trim bit
   logic                   usb_wr;       // usb settings write strobe
   logic [7:0]             nxt_rdata;    // read mux output
   logic                   nxt_hit;      // address mapped
   logic [7:0]             rdata_ff;     // registered read data
   logic                   rvalid_ff;    // read answer pulse
   logic                   hit_ff;       // mapped flag for last access
   resource_cfg_type [3:0] cfg_ff;       // registered settings
   logic [2:0]             fast_grp_ff;  // fast clock group out
   logic                   usb_out_ff;   // usb remap out
   logic                   gain_out_ff;  // gain trim out

   // bundle the access
   assign acc = '{wr_en: reg_wr_en, rd_en: reg_rd_en, addr: reg_addr, wdata: reg_wdata};

   // write strobe decode
   always_comb begin
      group_wr = '0;
      type_wr  = '0;
      remap_wr = '0;
      usb_wr   = 1'b0;
      if (acc.wr_en) begin
         unique case (acc.addr)
            USB_LDO_SETTINGS_TWO_OFF:       usb_wr      = 1'b1;
            REGULATOR_ENABLE_OUT_GROUP_OFF: group_wr[0] = 1'b1;
            REGULATOR_ENABLE_OUT_TYPE_OFF:  type_wr[0]  = 1'b1;
            REGULATOR_ENABLE_OUT_REMAP_OFF: remap_wr[0] = 1'b1;
            POWERON_RESET_OUT_GROUP_OFF:    group_wr[1] = 1'b1;
            POWERON_RESET_OUT_TYPE_OFF:     type_wr[1]  = 1'b1;
            POWERON_RESET_OUT_REMAP_OFF:    remap_wr[1] = 1'b1;
            CLOCK_REQUEST_OUT_GROUP_OFF:    group_wr[2] = 1'b1;
            CLOCK_REQUEST_OUT_TYPE_OFF:     type_wr[2]  = 1'b1;
            CLOCK_REQUEST_OUT_REMAP_OFF:    remap_wr[2] = 1'b1;
            SYSTEM_ENABLE_OUT_GROUP_OFF:    group_wr[3] = 1'b1;
            SYSTEM_ENABLE_OUT_TYPE_OFF:     type_wr[3]  = 1'b1;
            SYSTEM_ENABLE_OUT_REMAP_OFF:    remap_wr[3] = 1'b1;
            FAST_CLOCK_OUT_GROUP_OFF:       group_wr[4] = 1'b1;
            // unmapped writes ignored
            default: ;
         endcase
      end
   end

   // five group registers
   for (genvar g = 0; g < 5; g++) begin : g_group
      resource_group_reg u_group (
         .sys_clk    (sys_clk),
         .reset_n    (reset_n),
         .wr_en      (group_wr[g]),
         .wdata      (acc.wdata),
         .warm_reset (warm_reset[g]),
         .res_state  (res_state[4*g +: 4]),
         .reg_value  (group_val[g]),
         .group_sel  (group_sel[g]),
         .warm_cfg   (warm_cfg[g])
      );
   end

   // per-resource primary kind reset values
   localparam logic [3:0][2:0] KIND_RESETS =
      {SYSTEM_ENABLE_OUTPUT_KIND_RESET, CLKREQ_KIND_RESET, PORST_KIND_RESET, REGULATOR_ENABLE_OUTPUT_KIND_RESET};

   // four type and remap register pairs
   for (genvar k = 0; k < NUM_FULL_RES; k++) begin : g_kind
      resource_kind_remap_reg #(
         .KIND_RESET (KIND_RESETS[k])
      ) u_kind (
         .sys_clk     (sys_clk),
         .reset_n     (reset_n),
         .type_wr_en  (type_wr[k]),
         .remap_wr_en (remap_wr[k]),
         .wdata       (acc.wdata),
         .type_value  (type_val[k]),
         .remap_value (remap_val[k])
      );
   end

   // usb high ldo remap bit
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         usb_remap_ff <= USB_SLEEP_REMAP_RESET;
      end else if (usb_high_ldo_off) begin
         usb_remap_ff <= 1'b1;
      end else if (usb_wr) begin
         usb_remap_ff <= acc.wdata[USB_HIGH_LDO_SLEEP_REMAP_BIT];
      end
   end

   // gain trim bit, lives in the preceding settings register
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         gain_trim_ff <= GAIN_TRIM_RESET;
      end else if (gain_trim_wr_en) begin
         gain_trim_ff <= gain_trim_wdata;
      end
   end

   // read mux
   always_comb begin
      nxt_rdata = 8'h00;
      nxt_hit   = 1'b1;
      unique case (acc.addr)
         USB_LDO_SETTINGS_TWO_OFF:
            nxt_rdata = {4'h0, usb_remap_ff, 3'h0};
         REGULATOR_ENABLE_OUT_GROUP_OFF: nxt_rdata = group_val[0];
         REGULATOR_ENABLE_OUT_TYPE_OFF:  nxt_rdata = type_val[0];
         REGULATOR_ENABLE_OUT_REMAP_OFF: nxt_rdata = remap_val[0];
         POWERON_RESET_OUT_GROUP_OFF:    nxt_rdata = group_val[1];
         POWERON_RESET_OUT_TYPE_OFF:     nxt_rdata = type_val[1];
         POWERON_RESET_OUT_REMAP_OFF:    nxt_rdata = remap_val[1];
         CLOCK_REQUEST_OUT_GROUP_OFF:    nxt_rdata = group_val[2];
         CLOCK_REQUEST_OUT_TYPE_OFF:     nxt_rdata = type_val[2];
         CLOCK_REQUEST_OUT_REMAP_OFF:    nxt_rdata = remap_val[2];
         SYSTEM_ENABLE_OUT_GROUP_OFF:    nxt_rdata = group_val[3];
         SYSTEM_ENABLE_OUT_TYPE_OFF:     nxt_rdata = type_val[3];
         SYSTEM_ENABLE_OUT_REMAP_OFF:    nxt_rdata = remap_val[3];
         FAST_CLOCK_OUT_GROUP_OFF:       nxt_rdata = group_val[4];
         // unmapped reads zero
         default:                        nxt_hit   = 1'b0;
      endcase
   end

   // read answer registers
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_ff  <= 8'h00;
         rvalid_ff <= 1'b0;
         hit_ff    <= 1'b0;
      end else begin
         rvalid_ff <= acc.rd_en;
         if (acc.rd_en || acc.wr_en) begin
            hit_ff <= nxt_hit;
         end
         if (acc.rd_en) begin
            rdata_ff <= nxt_rdata;
         end
      end
   end

   // registered settings for the sequencer
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < NUM_FULL_RES; i++) begin
            cfg_ff[i] <= '{processor_group_select: GROUP_RESET,
                           warm_cfg: WARM_CFG_RESET,
                           secondary_resource_kind: SECONDARY_KIND_RESET,
                           primary_resource_kind: KIND_RESETS[i],
                           off_remap: OFF_REMAP_RESET,
                           sleep_remap: SLEEP_REMAP_RESET};
         end
         fast_grp_ff <= GROUP_RESET;
         usb_out_ff  <= USB_SLEEP_REMAP_RESET;
         gain_out_ff <= GAIN_TRIM_RESET;
      end else begin
         for (int i = 0; i < NUM_FULL_RES; i++) begin
            cfg_ff[i] <= '{processor_group_select: group_sel[i],
                           warm_cfg: warm_cfg[i],
                           secondary_resource_kind:
                              type_val[i][SECONDARY_KIND_MSB:SECONDARY_KIND_LSB],
                           primary_resource_kind:
                              type_val[i][PRIMARY_KIND_MSB:PRIMARY_KIND_LSB],
                           off_remap: remap_val[i][OFF_REMAP_MSB:OFF_REMAP_LSB],
                           sleep_remap: remap_val[i][SLEEP_REMAP_MSB:SLEEP_REMAP_LSB]};
         end
         fast_grp_ff <= group_sel[4];
         usb_out_ff  <= usb_remap_ff;
         gain_out_ff <= gain_trim_ff;
      end
   end

   // outputs straight from flops
   assign reg_rdata                = rdata_ff;
   assign reg_rvalid               = rvalid_ff;
   assign reg_hit                  = hit_ff;
   assign res_cfg                  = cfg_ff;
   assign fast_clock_output_group  = fast_grp_ff;
   assign usb_high_ldo_sleep_remap = usb_out_ff;
   assign gain_trim_low_bit        = gain_out_ff;

endmodule

// ### verification/host_access_model.sv
`timescale 1ns/1ps
// host side of the register access port
module host_access_model (
   // clock
   input  wire logic sys_clk,
   // register access strobes
   output logic      reg_wr_en,
   output logic      reg_rd_en,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata
);
   // idle bus at time zero
   initial begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end

   // one byte access, strobe held across one rising edge
   // settings changed by writes
   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      #10;
      reg_wr_en = wr;
      reg_rd_en = ~wr;
      reg_addr = a;
      reg_wdata = d;
      @(posedge sys_clk);
      #10;
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      // released bus shows the inverse, never a stale value
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
endmodule

// ### verification/power_resource_config_bank_props.sv
`timescale 1ns/1ps
// port-level checks of the register bank
module power_resource_config_bank_props
   import power_resource_pkg::*;
(
   // clock and reset
   input wire logic                   sys_clk,
   input wire logic                   reset_n,
   // register access
   input wire logic                   reg_rd_en,
   input wire logic [7:0]             reg_addr,
   input wire logic [7:0]             reg_rdata,
   input wire logic                   reg_rvalid,
   input wire logic                   reg_hit,
   // sequencer side
   input wire logic [4:0]             warm_reset,
   input wire logic                   usb_high_ldo_off,
   input wire resource_cfg_type [3:0] res_cfg,
   input wire logic                   usb_high_ldo_sleep_remap,
   // gain trim bit
   input wire logic                   gain_trim_wr_en,
   input wire logic                   gain_trim_wdata,
   input wire logic                   gain_trim_low_bit
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   // address classes
   wire mapped = (reg_addr >= USB_LDO_SETTINGS_TWO_OFF) && (reg_addr <= FAST_CLOCK_OUT_GROUP_OFF);
   wire is_type = (reg_addr == REGULATOR_ENABLE_OUT_TYPE_OFF)
      || (reg_addr == POWERON_RESET_OUT_TYPE_OFF)
      || (reg_addr == CLOCK_REQUEST_OUT_TYPE_OFF)
      || (reg_addr == SYSTEM_ENABLE_OUT_TYPE_OFF);

   a_read_answers: assert property (reg_rd_en |=> reg_rvalid)
      else $error("read strobe got no answer");
   a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd_en))
      else $error("read answer without a read");
   a_unmapped_zero: assert property (reg_rd_en && !mapped |=> reg_rdata == 8'h00 && !reg_hit)
      else $error("unmapped read not zero");
   a_mapped_hit: assert property (reg_rd_en && mapped |=> reg_hit)
      else $error("mapped read without hit");
   a_usb_reserved: assert property (reg_rd_en && reg_addr == USB_LDO_SETTINGS_TWO_OFF
      |=> (reg_rdata & 8'hF7) == 8'h00)
      else $error("usb settings reserved bits set");
   a_type_reserved: assert property (reg_rd_en && is_type |=> reg_rdata[7:5] == 3'h0)
      else $error("type reserved bits set");
   a_ldo_off_forces: assert property (usb_high_ldo_off [*3] |-> usb_high_ldo_sleep_remap)
      else $error("remap bit low while ldo off");
   a_warm_forces_all: assert property (warm_reset[0] && res_cfg[0].warm_cfg
      |-> ##[1:3] res_cfg[0].processor_group_select == 3'h7)
      else $error("warm reset did not force all groups");
   a_rdata_holds: assert property (!reg_rd_en |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   a_gain_trim_load: assert property (gain_trim_wr_en
      |-> ##2 gain_trim_low_bit == $past(gain_trim_wdata, 2))
      else $error("gain trim bit did not take the written value");

   // main scenarios reached
   c_unmapped: cover property (reg_rd_en && !mapped);
   c_warm: cover property (warm_reset[0] && res_cfg[0].warm_cfg);
   c_ldo_off: cover property (usb_high_ldo_off [*3]);
endmodule

bind power_resource_config_bank power_resource_config_bank_props i_power_resource_config_bank_props (
   .sys_clk, .reset_n, .reg_rd_en, .reg_addr, .reg_rdata, .reg_rvalid, .reg_hit,
   .warm_reset, .usb_high_ldo_off, .res_cfg, .usb_high_ldo_sleep_remap,
   .gain_trim_wr_en, .gain_trim_wdata, .gain_trim_low_bit);

// ### verification/test_power_resource_config_bank.sv
`timescale 1ns/1ps
// self-checking bench for the resource configuration bank
module test_power_resource_config_bank;
   import power_resource_pkg::*;
   logic                   sys_clk, reset_n, reg_wr_en, reg_rd_en, reg_rvalid, reg_hit;
   logic [7:0]             reg_addr, reg_wdata, reg_rdata;
   logic [4:0]             warm_reset;
   logic [19:0]            res_state;
   logic                   usb_high_ldo_off, gain_trim_wr_en, gain_trim_wdata;
   logic                   usb_high_ldo_sleep_remap, gain_trim_low_bit;
   logic [2:0]             fast_clock_output_group;
   resource_cfg_type [3:0] res_cfg;
   logic [7:0]             shadow [8'hD9:8'hE6]; // expected register images
   logic [8:0]             exp_q [$];            // expected {hit, data} per read
   logic [2:0]             kinds [4] = '{REGULATOR_ENABLE_OUTPUT_KIND_RESET, PORST_KIND_RESET,
                                         CLKREQ_KIND_RESET, SYSTEM_ENABLE_OUTPUT_KIND_RESET};
   int                     failures, num_checks, k;
   int                     seed = 32'hcf062680;

   host_access_model i_host_access_model (.sys_clk(sys_clk), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
   power_resource_config_bank i_power_resource_config_bank (.sys_clk(sys_clk),
      .reset_n(reset_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_hit(reg_hit),
      .warm_reset(warm_reset), .res_state(res_state), .usb_high_ldo_off(usb_high_ldo_off),
      .gain_trim_wr_en(gain_trim_wr_en), .gain_trim_wdata(gain_trim_wdata),
      .res_cfg(res_cfg), .fast_clock_output_group(fast_clock_output_group),
      .usb_high_ldo_sleep_remap(usb_high_ldo_sleep_remap),
      .gain_trim_low_bit(gain_trim_low_bit));

   // writable bits per address
   function automatic logic [7:0] wmask(input int a);
      if (a == 'hD9) return 8'h08;
      if (a < 'hDA || a > 'hE6) return 8'h00;
      case ((a - 'hDA) % 3)
         0: return 8'hF0;
         1: return 8'h1F;
         default: return 8'hFF;
      endcase
   endfunction

   // count and compare one result
   task automatic check(input logic [8:0] got, input logic [8:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected result at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // host write, shadow follows the writable bits
   task automatic wr(input int a, input logic [7:0] d);
      i_host_access_model.access(1'b1, a[7:0], d);
      if (wmask(a) != 8'h00) shadow[a] = d & wmask(a);
      if (a == 'hD9 && usb_high_ldo_off) shadow[a] = 8'h08;
   endtask

   // host read, expectation noted first
   task automatic rd(input int a);
      logic [7:0] e;
      e = 8'h00;
      if (a >= 'hD9 && a <= 'hE6) e = shadow[a];
      if (wmask(a) == 8'hF0) e[3:0] = res_state[((a - 'hDA) / 3) * 4 +: 4];
      exp_q.push_back({(a >= 'hD9 && a <= 'hE6), e});
      i_host_access_model.access(1'b0, a[7:0], 8'h00);
   endtask

   // answer watcher takes the oldest note
   always @(negedge sys_clk) begin
      if (reg_rvalid === 1'b1) begin
         if (exp_q.size() == 0) begin
            failures++;
            $display("unexpected answer at %0t: got %h expected %h", $time,
                     {reg_hit, reg_rdata}, 9'h000);
         end else check({reg_hit, reg_rdata}, exp_q.pop_front());
      end
   end

   // end of run
   task automatic conclude();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // clock
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   // watchdog
   initial begin
      #3000000;
      failures++;
      conclude();
   end

   // main sequence
   initial begin
      reset_n = 1'b0;
      warm_reset = 5'h00;
      res_state = 20'h00000;
      usb_high_ldo_off = 1'b0;
      gain_trim_wr_en = 1'b0;
      gain_trim_wdata = 1'b0;
      shadow[8'hD9] = 8'h08;
      for (int a = 'hDA; a <= 'hE6; a++) begin
         k = (a - 'hDA) / 3;
         case ((a - 'hDA) % 3)
            0: shadow[a] = 8'hE0;
            1: shadow[a] = {5'h00, kinds[k]};
            default: shadow[a] = 8'h08;
         endcase
      end
      repeat (12) @(posedge sys_clk);
      #10 reset_n = 1'b1;
      // reset images plus both unmapped neighbours
      for (int a = 'hD8; a <= 'hE7; a++) rd(a);
      check({8'h00, gain_trim_low_bit}, {8'h00, GAIN_TRIM_RESET});
      check({6'h00, fast_clock_output_group}, {6'h00, GROUP_RESET});
      @(posedge sys_clk);
      #10 res_state = 20'($random(seed));
      // random images, reserved bits must stay zero
      for (int a = 'hD8; a <= 'hE7; a++) wr(a, 8'($random(seed)));
      for (int a = 'hD8; a <= 'hE7; a++) rd(a);
      // settings handed to the sequencer follow the written images
      for (int i = 0; i < 4; i++) begin
         check({res_cfg[i].processor_group_select, res_cfg[i].warm_cfg,
                res_cfg[i].secondary_resource_kind, res_cfg[i].primary_resource_kind},
               {shadow['hDA + 3 * i][7:4], shadow['hDB + 3 * i][4:0]});
         check({1'b0, res_cfg[i].off_remap, res_cfg[i].sleep_remap},
               {1'b0, shadow['hDC + 3 * i]});
      end
      check({6'h00, fast_clock_output_group}, {6'h00, shadow[8'hE6][7:5]});
      // every group code
      for (int g = 0; g < 8; g++) begin
         wr('hE0, {g[2:0], 5'h00});
         rd('hE0);
      end
      // warm reset with and without the config bit, each resource
      for (int r = 0; r < 5; r++) begin
         for (int c = 1; c >= 0; c--) begin
            wr('hDA + 3 * r, {3'h1, c[0], 4'h0});
            repeat (3) @(posedge sys_clk);
            #10 warm_reset[r] = 1'b1;
            @(posedge sys_clk);
            #10 warm_reset[r] = 1'b0;
            if (c == 1) shadow['hDA + 3 * r][7:5] = 3'h7;
            repeat (2) @(posedge sys_clk);
            rd('hDA + 3 * r);
         end
      end
      // ldo off forces the remap bit over host writes
      wr('hD9, 8'h00);
      rd('hD9);
      #10 usb_high_ldo_off = 1'b1;
      shadow[8'hD9] = 8'h08;
      repeat (3) @(posedge sys_clk);
      wr('hD9, 8'h00);
      rd('hD9);
      #10 usb_high_ldo_off = 1'b0;
      wr('hD9, 8'h00);
      rd('hD9);
      // test-only trim bit written by its own pulse
      #10 gain_trim_wdata = 1'b1;
      gain_trim_wr_en = 1'b1;
      @(posedge sys_clk);
      #10 gain_trim_wr_en = 1'b0;
      repeat (2) @(posedge sys_clk);
      #10 check({8'h00, gain_trim_low_bit}, 9'h001);
      check({8'h00, usb_high_ldo_sleep_remap}, {8'h00, shadow[8'hD9][3]});
      repeat (4) @(posedge sys_clk);
      if (exp_q.size() != 0) begin
         failures++;
         $display("unexpected missing answers at %0t: got %h expected %h", $time,
                  exp_q.size(), 0);
      end
      conclude();
   end
endmodule
